// ### logic/lbdc_pkg.sv
// Purpose: shared constants and types of the backlight dimming control
// Assumes: 50 MHz hclk, AHB-Lite register access, word-aligned registers
// Notes:   timing counts are in switching periods after any divide
package lbdc_pkg;

  // register byte offsets
  localparam logic [7:0] LBDC_CTRL_OFS    = 8'h00;
  localparam logic [7:0] LBDC_STATUS_OFS  = 8'h04;
  localparam logic [7:0] LBDC_LEVEL_OFS   = 8'h08;
  localparam logic [7:0] LBDC_STRINGS_OFS = 8'h0C;

  // field positions and reset values
  localparam int         LBDC_CTRL_SHDN_BIT  = 0;
  localparam logic [0:0] LBDC_CTRL_RST       = 1'h0;
  localparam int         LBDC_ST_STATE_LSB   = 0;
  localparam int         LBDC_ST_MODE_LSB    = 2;
  localparam int         LBDC_ST_COUNT_LSB   = 4;
  localparam int         LBDC_ST_APPLIED_LSB = 8;
  localparam int         LBDC_ST_OTEMP_BIT   = 12;
  localparam int         LBDC_ST_DIV_BIT     = 13;
  localparam int         LBDC_STR_REMOVED_LSB = 8;

  // timing counts in switching periods
  localparam logic [8:0] LBDC_TMO_UNDIV  = 9'h100;
  localparam logic [8:0] LBDC_TMO_DIV    = 9'h040;
  localparam logic [1:0] LBDC_DIV_LAST   = 2'h3;

  // current levels in 1/256 of full scale, LBDC_SIXTEENTHS in 1/16
  localparam logic [8:0] LBDC_LVL_FULL   = 9'h100;
  localparam logic [8:0] LBDC_LVL_SOFT   = 9'h010;
  localparam logic [4:0] LBDC_SIXTEENTHS = 5'h10;

  typedef enum logic [1:0] {
    LBDC_OFF,
    LBDC_HOLD,
    LBDC_SOFT,
    LBDC_RUN
  } lbdc_state_t;

  typedef enum logic [1:0] {
    LBDC_MODE_SERIAL,
    LBDC_MODE_PWM,
    LBDC_MODE_ANALOG
  } lbdc_mode_t;

  // host-side control pins
  typedef struct packed {
    logic       enable;
    logic       pwm;
    logic       analog_dim_input;
    logic       freq_div;
    logic [2:0] string_select;
  } lbdc_ctrl_pins_t;

  // analog comparator flags
  typedef struct packed {
    logic       osc;
    logic       over_temperature_shutdown;
    logic       switch_current_limit;
    logic       overvoltage;
    logic [7:0] sink_at_regulation;
    logic [7:0] sink_collapsed;
  } lbdc_flags_t;

endpackage : lbdc_pkg

// ### logic/lbdc_top.sv
// Purpose: dimming mode select, pulse decode, timeouts, soft start, faults
// Assumes: all pin and comparator inputs are asynchronous to hclk
// Notes:   sink_current_level is in 1/256 of full-scale reference
//
// Summary of operation
// - enable pulses, analog low: serial mode
// - count N gives (16-N)/16, zero full
// - counter wraps on sixteenth pulse
// - pulses ignored during hold; full scale
// - long enable high ends sequence
// - end applies count, then clears counter
// - all low past delay: sinks, boost off
// - after ramp: soft start, 1A, 1/16
// - sinks at regulation: 2A, full scale
// - pwm alone: full scale after soft start
// - pwm low: immediate shutdown
// - analog alone enters analog mode
// - analog duty scales reference
// - analog mode uses same soft start
// - switch pulse ends at current limit
// - over temperature flag forces shutdown
// - overvoltage removes collapsed strings from loop
// - removed strings stay enabled, restore later
// - loop holds lowest regulated sink
// - divide input divides switching by four
// - shutdown delay 256 or 64 pulses
// - only selected strings enabled, regulated
`timescale 1ns/10ps
module lbdc_top (
  // clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [7:0]                haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic [31:0]                    hrdata,
  output logic                           hreadyout,
  output logic                           hresp,
  // pins and comparator flags
  input  wire lbdc_pkg::lbdc_ctrl_pins_t pins,
  input  wire lbdc_pkg::lbdc_flags_t     flags,
  // analog core controls
  output logic [7:0]                     sink_enable,
  output logic [7:0]                     regulated_strings,
  output logic [8:0]                     sink_current_level,
  output logic                           boost_gate,
  output logic                           boost_limit_high,
  output logic                           boost_raise
);

  localparam int SW = $bits(lbdc_pkg::lbdc_ctrl_pins_t)
                    + $bits(lbdc_pkg::lbdc_flags_t);

  // three-stage input capture
  logic [SW-1:0]             s1_q;
  logic [SW-1:0]             s2_q;
  logic [SW-1:0]             s3_q;
  logic [SW-1:0]             filt_q;
  logic [SW-1:0]             agree;
  lbdc_pkg::lbdc_ctrl_pins_t pin_f;
  lbdc_pkg::lbdc_flags_t     flg_f;
  lbdc_pkg::lbdc_ctrl_pins_t pin_p_q;
  logic                      ovp_p_q;
  logic                      osc_p_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= {pins, flags};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  // value changes only when second and third stages agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      filt_q <= '0;
    else
      filt_q <= (s3_q & agree) | (filt_q & ~agree);
  end

  assign {pin_f, flg_f} = filt_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_p_q <= '0;
      ovp_p_q <= 1'b0;
      osc_p_q <= 1'b0;
    end
    else
    begin
      pin_p_q <= pin_f;
      ovp_p_q <= flg_f.overvoltage;
      osc_p_q <= flg_f.osc;
    end
  end

  logic en_rise;
  logic en_fall;
  logic any_edge;
  logic all_low;
  logic ovp_event;
  assign en_rise   = pin_f.enable & ~pin_p_q.enable;
  assign en_fall   = ~pin_f.enable & pin_p_q.enable;
  assign any_edge  = (pin_f.enable ^ pin_p_q.enable)
                   | (pin_f.analog_dim_input ^ pin_p_q.analog_dim_input)
                   | (pin_f.pwm ^ pin_p_q.pwm);
  assign all_low   = ~pin_f.enable & ~pin_f.pwm & ~pin_f.analog_dim_input;
  assign ovp_event = flg_f.overvoltage & ~ovp_p_q;

  // switching tick, optionally divided by four
  logic [1:0] div_q;
  logic       osc_rise;
  logic       tick;
  assign osc_rise = flg_f.osc & ~osc_p_q;
  assign tick     = osc_rise
                  & (~pin_f.freq_div | (div_q == lbdc_pkg::LBDC_DIV_LAST));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_q <= 2'h0;
    else if (osc_rise)
      div_q <= div_q + 2'h1;
  end

  // shared timeout counter, restarts on any enable, pwm or analog edge
  logic [8:0] tmr_q;
  logic [8:0] tmo;
  logic       tmo_hit;
  assign tmo     = pin_f.freq_div ? lbdc_pkg::LBDC_TMO_DIV
                                  : lbdc_pkg::LBDC_TMO_UNDIV;
  assign tmo_hit = tick & (tmr_q == tmo - 9'h001);

  lbdc_pkg::lbdc_state_t state_q;
  lbdc_pkg::lbdc_mode_t  mode_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tmr_q <= 9'h000;
    else if (any_edge || state_q == lbdc_pkg::LBDC_OFF)
      tmr_q <= 9'h000;
    else if (tick && tmr_q != 9'h1FF)
      tmr_q <= tmr_q + 9'h001;
  end

  // register-controlled shutdown
  logic [0:0] ctrl_q;

  // string selection and open-string removal
  logic [7:0] enabled;
  logic [7:0] removed_q;
  logic [7:0] regulated;

  function automatic logic [7:0] sel_mask(input logic [2:0] sel);
    logic [8:0] one_hot;
    one_hot  = 9'h001 << ({6'h00, sel} + 9'h001);
    sel_mask = one_hot[7:0] - 8'h01;
    if (sel == 3'h7)
      sel_mask = 8'hFF;
  endfunction : sel_mask

  assign enabled   = sel_mask(pin_f.string_select);
  assign regulated = enabled & ~removed_q;

  // mode and power state
  logic shut_now;
  logic soft_done;
  assign shut_now  = flg_f.over_temperature_shutdown
                   | ctrl_q[0];
  assign soft_done = ((regulated & ~flg_f.sink_at_regulation) == 8'h00);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= lbdc_pkg::LBDC_OFF;
      mode_q  <= lbdc_pkg::LBDC_MODE_SERIAL;
    end
    else if (shut_now)
      state_q <= lbdc_pkg::LBDC_OFF;
    else
    begin
      case (state_q)
        lbdc_pkg::LBDC_OFF:
        begin
          if (!all_low)
          begin
            state_q <= lbdc_pkg::LBDC_HOLD;
            if (pin_f.enable && !pin_f.analog_dim_input)
              mode_q <= lbdc_pkg::LBDC_MODE_SERIAL;
            else if (pin_f.pwm && !pin_f.enable
                     && !pin_f.analog_dim_input)
              mode_q <= lbdc_pkg::LBDC_MODE_PWM;
            else
              mode_q <= lbdc_pkg::LBDC_MODE_ANALOG;
          end
        end
        lbdc_pkg::LBDC_HOLD:
        begin
          if (mode_q == lbdc_pkg::LBDC_MODE_PWM && !pin_f.pwm)
            state_q <= lbdc_pkg::LBDC_OFF;
          else if (all_low && tmo_hit)
            state_q <= lbdc_pkg::LBDC_OFF;
          else if (!all_low && tmo_hit)
            state_q <= lbdc_pkg::LBDC_SOFT;
        end
        lbdc_pkg::LBDC_SOFT, lbdc_pkg::LBDC_RUN:
        begin
          if (mode_q == lbdc_pkg::LBDC_MODE_PWM && !pin_f.pwm)
            state_q <= lbdc_pkg::LBDC_OFF;
          else if (mode_q != lbdc_pkg::LBDC_MODE_PWM && all_low
                   && tmo_hit)
            state_q <= lbdc_pkg::LBDC_OFF;
          else if (state_q == lbdc_pkg::LBDC_SOFT && soft_done)
            state_q <= lbdc_pkg::LBDC_RUN;
        end
        default:
          state_q <= lbdc_pkg::LBDC_OFF;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      removed_q <= 8'h00;
    else if (state_q == lbdc_pkg::LBDC_OFF)
      removed_q <= 8'h00;
    else if (ovp_event)
      removed_q <= enabled & flg_f.sink_collapsed;
  end

  // serial pulse counting after the hold time
  logic [3:0] count_q;
  logic [3:0] applied_q;
  logic       pulses_q;
  logic       counting;
  assign counting = mode_q == lbdc_pkg::LBDC_MODE_SERIAL
                  && (state_q == lbdc_pkg::LBDC_SOFT
                      || state_q == lbdc_pkg::LBDC_RUN);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_q   <= 4'h0;
      applied_q <= 4'h0;
      pulses_q  <= 1'b0;
    end
    else if (!counting)
    begin
      count_q   <= 4'h0;
      applied_q <= 4'h0;
      pulses_q  <= 1'b0;
    end
    else if (en_fall)
    begin
      count_q  <= count_q + 4'h1;
      pulses_q <= 1'b1;
    end
    else if (pulses_q && pin_f.enable && tmo_hit)
    begin
      applied_q <= count_q;
      count_q   <= 4'h0;
      pulses_q  <= 1'b0;
    end
  end

  // analog duty measurement over each input period
  logic [11:0] per_cnt_q;
  logic [11:0] hi_cnt_q;
  logic [8:0]  duty_q;
  logic        adim_rise;
  logic [19:0] duty_full;
  assign adim_rise = pin_f.analog_dim_input & ~pin_p_q.analog_dim_input;
  assign duty_full = ({8'h00, hi_cnt_q} << 8)
                   / {8'h00, (per_cnt_q == 12'h000) ? 12'h001 : per_cnt_q};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      per_cnt_q <= 12'h000;
      hi_cnt_q  <= 12'h000;
      duty_q    <= lbdc_pkg::LBDC_LVL_FULL;
    end
    else if (adim_rise)
    begin
      duty_q    <= (duty_full > {11'h000, lbdc_pkg::LBDC_LVL_FULL})
                 ? lbdc_pkg::LBDC_LVL_FULL : duty_full[8:0];
      per_cnt_q <= 12'h001;
      hi_cnt_q  <= 12'h001;
    end
    else if (per_cnt_q != 12'hFFF)
    begin
      per_cnt_q <= per_cnt_q + 12'h001;
      if (pin_f.analog_dim_input)
        hi_cnt_q <= hi_cnt_q + 12'h001;
    end
  end

  // sink level selection
  logic [8:0] level_d;
  logic [4:0] sixteenths;
  assign sixteenths = (applied_q == 4'h0) ? lbdc_pkg::LBDC_SIXTEENTHS
                    : lbdc_pkg::LBDC_SIXTEENTHS - {1'b0, applied_q};

  always_comb
  begin
    level_d = 9'h000;
    case (state_q)
      lbdc_pkg::LBDC_SOFT:
        level_d = lbdc_pkg::LBDC_LVL_SOFT;
      lbdc_pkg::LBDC_RUN:
      begin
        case (mode_q)
          lbdc_pkg::LBDC_MODE_SERIAL:
            level_d = {sixteenths, 4'h0};
          lbdc_pkg::LBDC_MODE_ANALOG:
            level_d = duty_q;
          default:
            level_d = lbdc_pkg::LBDC_LVL_FULL;
        endcase
      end
      default:
        level_d = 9'h000;
    endcase
  end

  // analog core outputs
  logic active;
  assign active = state_q == lbdc_pkg::LBDC_SOFT
               || state_q == lbdc_pkg::LBDC_RUN;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sink_enable        <= 8'h00;
      regulated_strings  <= 8'h00;
      sink_current_level <= 9'h000;
      boost_limit_high   <= 1'b0;
      boost_raise        <= 1'b0;
    end
    else
    begin
      sink_enable        <= active ? enabled : 8'h00;
      regulated_strings  <= active ? regulated : 8'h00;
      sink_current_level <= level_d;
      boost_limit_high   <= state_q == lbdc_pkg::LBDC_RUN;
      boost_raise        <= active
                          && (regulated & ~flg_f.sink_at_regulation)
                             != 8'h00;
    end
  end

  // boost switch: on at each tick while boost_raise is set, off at current limit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      boost_gate <= 1'b0;
    else if (!active || flg_f.switch_current_limit)
      boost_gate <= 1'b0;
    else if (tick)
      boost_gate <= boost_raise;
  end

  // ahb-lite slave, zero wait states
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       take;
  logic [31:0] rd_d;
  assign take = hsel & htrans[1] & hready;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (haddr)
      lbdc_pkg::LBDC_CTRL_OFS:
        rd_d[lbdc_pkg::LBDC_CTRL_SHDN_BIT] = ctrl_q[0];
      lbdc_pkg::LBDC_STATUS_OFS:
      begin
        rd_d[lbdc_pkg::LBDC_ST_STATE_LSB +: 2]   = state_q;
        rd_d[lbdc_pkg::LBDC_ST_MODE_LSB +: 2]    = mode_q;
        rd_d[lbdc_pkg::LBDC_ST_COUNT_LSB +: 4]   = count_q;
        rd_d[lbdc_pkg::LBDC_ST_APPLIED_LSB +: 4] = applied_q;
        rd_d[lbdc_pkg::LBDC_ST_OTEMP_BIT] =
          flg_f.over_temperature_shutdown;
        rd_d[lbdc_pkg::LBDC_ST_DIV_BIT]   = pin_f.freq_div;
      end
      lbdc_pkg::LBDC_LEVEL_OFS:
        rd_d[8:0] = sink_current_level;
      lbdc_pkg::LBDC_STRINGS_OFS:
      begin
        rd_d[7:0] = enabled;
        rd_d[lbdc_pkg::LBDC_STR_REMOVED_LSB +: 8] = removed_q;
      end
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      if (take)
        wr_addr_q <= haddr;
      if (take && !hwrite)
        hrdata <= rd_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= lbdc_pkg::LBDC_CTRL_RST;
    else if (wr_pend_q && wr_addr_q == lbdc_pkg::LBDC_CTRL_OFS)
      ctrl_q[0] <= hwdata[lbdc_pkg::LBDC_CTRL_SHDN_BIT];
  end

endmodule : lbdc_top

// ### sim/lbdc_properties.sv
// Purpose: port checks of the backlight dimming control
// Assumes: pins and flags change only just after hclk edges
// Notes:   bound to lbdc_top at the foot of this file
`timescale 1ns/10ps
module lbdc_properties (
  // clock and reset
  input wire logic                      hclk,
  input wire logic                      hresetn,
  // pins and flags
  input wire lbdc_pkg::lbdc_ctrl_pins_t pins,
  input wire lbdc_pkg::lbdc_flags_t     flags,
  // core controls
  input wire logic [7:0]                sink_enable,
  input wire logic [7:0]                regulated_strings,
  input wire logic [8:0]                sink_current_level,
  input wire logic                      boost_gate,
  input wire logic                      boost_limit_high
);
  logic all_reg;
  // every regulated sink reports regulation
  assign all_reg = (flags.sink_at_regulation | ~regulated_strings) == 8'hFF;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_soft_level;
    sink_enable != 8'h00 && !boost_limit_high
      |-> sink_current_level == lbdc_pkg::LBDC_LVL_SOFT;
  endproperty
  a_soft_level: assert property (p_soft_level)
    else $error("soft start level wrong");
  property p_run_entry;
    (sink_enable != 8'h00 && all_reg) [*8] |-> boost_limit_high;
  endproperty
  a_run_entry: assert property (p_run_entry)
    else $error("soft start not left");
  property p_boost_off;
    sink_enable == 8'h00 && $past(sink_enable) == 8'h00 |-> !boost_gate;
  endproperty
  a_boost_off: assert property (p_boost_off)
    else $error("boost on while sinks off");
  property p_subset;
    (regulated_strings & ~sink_enable) == 8'h00;
  endproperty
  a_subset: assert property (p_subset)
    else $error("regulated string not enabled");
  property p_ocp;
    flags.switch_current_limit [*6] |-> !boost_gate;
  endproperty
  a_ocp: assert property (p_ocp)
    else $error("switch on past current limit");
  property p_otemp;
    flags.over_temperature_shutdown [*8]
      |-> sink_enable == 8'h00 && !boost_gate;
  endproperty
  a_otemp: assert property (p_otemp)
    else $error("running while over temperature");
  property p_sel;
    pins.string_select == $past(pins.string_select, 8)
      && sink_enable != 8'h00
      |-> sink_enable == 8'hFF >> (3'h7 - pins.string_select);
  endproperty
  a_sel: assert property (p_sel)
    else $error("enabled strings differ from select");
  property p_level_max;
    sink_current_level <= lbdc_pkg::LBDC_LVL_FULL;
  endproperty
  a_level_max: assert property (p_level_max)
    else $error("level above full scale");
  property p_shdn_hold;
    sink_enable != 8'h00 && !pins.pwm && $past(pins.pwm, 8) == 1'b0
      && $fell(pins.enable) |-> ##1 (sink_enable != 8'h00) [*8];
  endproperty
  a_shdn_hold: assert property (p_shdn_hold)
    else $error("sinks dropped inside shutdown delay");
  property p_pwm_off;
    $fell(pins.pwm) && !pins.enable && !pins.analog_dim_input
      |-> ##[1:8] sink_enable == 8'h00;
  endproperty
  a_pwm_off: assert property (p_pwm_off)
    else $error("pwm low did not shut down");
endmodule : lbdc_properties

bind lbdc_top lbdc_properties i_props (
  .hclk, .hresetn, .pins, .flags, .sink_enable, .regulated_strings,
  .sink_current_level, .boost_gate, .boost_limit_high
);

// ### sim/lbdc_host_model.sv
// Purpose: host model driving enable, pwm and analog dimming pins
// Assumes: pulses of 8 cycles low and 8 high pass the input filter
// Notes:   analog pattern is 16 high in a 64 cycle period
`timescale 1ns/10ps
module lbdc_host_model (
  // clock
  input wire logic                 hclk,
  // pins toward the device
  output lbdc_pkg::lbdc_ctrl_pins_t pins
);
  logic       analog_dim_input_on;
  logic [5:0] ph;
  initial
  begin
    pins = '0;
    analog_dim_input_on = 1'b0;
    ph = 6'h00;
  end
  // 781 kHz analog dimming pattern
  always @(posedge hclk)
  begin
    if (analog_dim_input_on)
    begin
      ph <= ph + 6'h01;
      pins.analog_dim_input <= ph < 6'h10;
    end
  end
  task automatic set_pins(input logic [6:0] v);
    @(posedge hclk);
    pins <= v;
  endtask : set_pins
  task automatic run_analog_dim_input(input logic on);
    analog_dim_input_on <= on;
  endtask : run_analog_dim_input
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      pins.enable <= 1'b0;
      repeat (8) @(posedge hclk);
      pins.enable <= 1'b1;
      repeat (8) @(posedge hclk);
    end
  endtask : pulse
endmodule : lbdc_host_model

// ### sim/tb.sv
// Purpose: self-checking bench of the backlight dimming control
// Assumes: osc runs at a quarter of hclk, one tick is 4 cycles
// Notes:   T cycles cover 256 ticks with margin
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [4:0] n;
    logic [8:0] lvl;
  } lbdc_row_t;
  localparam int T = 1100;
  logic                      hclk, hresetn, hsel, hwrite;
  logic                      hreadyout, hresp, boost_gate;
  logic                      boost_limit_high, boost_raise;
  logic [1:0]                htrans, oc;
  logic [2:0]                hsize;
  logic [7:0]                haddr, sink_enable, regulated_strings;
  logic [8:0]                sink_current_level;
  logic [31:0]               hwdata, hrdata, rd;
  lbdc_pkg::lbdc_ctrl_pins_t pins;
  lbdc_pkg::lbdc_flags_t     flags;
  int                        miscompares, n_tests;
  lbdc_row_t                 rows [6] = '{'{5'h01, 9'h0F0},
    '{5'h05, 9'h0B0}, '{5'h0C, 9'h040}, '{5'h0F, 9'h010},
    '{5'h10, 9'h100}, '{5'h11, 9'h0F0}};

  lbdc_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .flags(flags), .sink_enable(sink_enable),
    .regulated_strings(regulated_strings),
    .sink_current_level(sink_current_level), .boost_gate(boost_gate),
    .boost_limit_high(boost_limit_high), .boost_raise(boost_raise)
  );
  lbdc_host_model i_host (
    .hclk(hclk),
    .pins(pins)
  );

  always #10 hclk = ~hclk;
  // switching oscillator at a quarter of hclk
  always @(posedge hclk)
  begin
    oc <= oc + 2'h1;
    flags.osc <= oc[1];
  end

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdchk
  task automatic stop_test;
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  initial
  begin
    #1000000;
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    flags = '0;
    oc = 2'h0;
    miscompares = 0;
    n_tests = 0;
    wt(12);
    hresetn <= 1'b1;
    rdchk(lbdc_pkg::LBDC_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
    chk(32'(hresp), 32'h0);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'hFFFF, 32'h0);
    ahb(1'b1, 8'h10, 32'hFFFFFFFF);
    rdchk(8'h10, 32'hFFFFFFFF, 32'h0);
    i_host.set_pins(7'h42);
    i_host.pulse(3);
    wt(T);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'hF, 32'h2);
    chk(32'(sink_enable), 32'h07);
    chk(32'(sink_current_level), 32'h010);
    flags.sink_at_regulation <= 8'hFF;
    wt(10);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'hFFF, 32'h3);
    chk(32'(sink_current_level), 32'h100);
    chk(32'(boost_limit_high), 32'h1);
    chk(32'(boost_raise), 32'h0);
    foreach (rows[i])
    begin
      i_host.pulse(int'(rows[i].n));
      wt(T);
      rdchk(lbdc_pkg::LBDC_LEVEL_OFS, 32'h1FF, 32'(rows[i].lvl));
      rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'hFF0,
            {20'h0, rows[i].n[3:0], 8'h00});
    end
    flags.sink_collapsed <= 8'h02;
    flags.overvoltage <= 1'b1;
    wt(10);
    chk(32'(regulated_strings), 32'h05);
    chk(32'(sink_enable), 32'h07);
    rdchk(lbdc_pkg::LBDC_STRINGS_OFS, 32'hFFFF, 32'h0207);
    flags.overvoltage <= 1'b0;
    flags.sink_collapsed <= 8'h00;
    wt(10);
    flags.overvoltage <= 1'b1;
    wt(10);
    chk(32'(regulated_strings), 32'h07);
    flags.overvoltage <= 1'b0;
    flags.over_temperature_shutdown <= 1'b1;
    wt(10);
    chk({sink_enable, boost_gate}, 32'h0);
    flags.over_temperature_shutdown <= 1'b0;
    wt(10);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'h3, 32'h1);
    wt(T);
    ahb(1'b1, lbdc_pkg::LBDC_CTRL_OFS, 32'h1);
    rdchk(lbdc_pkg::LBDC_CTRL_OFS, 32'hFFFFFFFF, 32'h1);
    chk(32'(sink_enable), 32'h0);
    ahb(1'b1, lbdc_pkg::LBDC_CTRL_OFS, 32'h0);
    wt(T);
    i_host.set_pins(7'h02);
    wt(T - 100);
    chk(32'(sink_enable), 32'h07);
    wt(200);
    chk({sink_enable, boost_gate}, 32'h0);
    i_host.set_pins(7'h22);
    wt(T);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'hF, 32'h7);
    chk(32'(sink_current_level), 32'h100);
    i_host.set_pins(7'h02);
    wt(8);
    chk(32'(sink_enable), 32'h0);
    flags.sink_at_regulation <= 8'h00;
    i_host.set_pins(7'h12);
    wt(T);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'hF, 32'hA);
    chk(32'(sink_current_level), 32'h010);
    chk(32'({boost_raise, boost_gate}), 32'h3);
    flags.switch_current_limit <= 1'b1;
    wt(8);
    chk(32'(boost_gate), 32'h0);
    flags.switch_current_limit <= 1'b0;
    flags.sink_at_regulation <= 8'hFF;
    i_host.run_analog_dim_input(1'b1);
    wt(300);
    chk(32'(sink_current_level inside {[9'h03E:9'h042]}), 32'h1);
    i_host.run_analog_dim_input(1'b0);
    // divided ticks: 64 ticks span the same cycles as 256 undivided
    i_host.set_pins(7'h1C);
    wt(10);
    rdchk(lbdc_pkg::LBDC_STATUS_OFS, 32'h2000, 32'h2000);
    i_host.set_pins(7'h0C);
    wt(T - 100);
    chk(32'(sink_enable), 32'h1F);
    wt(200);
    chk({sink_enable, boost_gate}, 32'h0);
    stop_test();
  end
endmodule : tb
